/* File: logic/ssrc_ctrl.sv */
// controller end: self-refresh, user refresh and csr side-band logic
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - request enters self-refresh, then acknowledge
// - release exits; ack drops after exit
// - handshakes live on the main clock
// - user refresh beats queued reads/writes
// - one-cycle ack after refresh issued
// - held request gives a refresh every second cycle
// - refresh runs capped at nine
// - csr slave 32-bit, fixed address width
// - csr on main clock, data-synchronous
// - csr changes timing, widths, behaviour live
// - each feature removable at build time
module ssrc_ctrl #(
  parameter bit EN_SR = 1'b1,
  parameter bit EN_REF = 1'b1,
  parameter bit EN_CSR = 1'b1
) (
  input wire logic ref_clk,               // main controller clock
  input wire logic resetn,                // async reset, active low
  ssrc_if.ctrl bus,                       // user side-band and csr
  input wire logic q_pending,             // reads/writes waiting in queue
  input wire logic cmd_ready,             // memory command path can take a command
  output ssrc_pkg::ssrc_cmd_e cmd_out,    // side-band command to memory path
  output logic q_hold,                    // stall the read/write queue
  output logic [ssrc_pkg::CSR_DW-1:0] timing_cfg, // live timing setting
  output logic [ssrc_pkg::CSR_DW-1:0] addrw_cfg   // live address width setting
);
  import ssrc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ENTER, ST_IN_SR, ST_EXIT, ST_REF} ssrc_state_e;

  ssrc_state_e state_ff, nxt_state;
  logic [CNT_W-1:0] wait_ff, nxt_wait;
  logic [3:0] run_ff, nxt_run;
  logic sr_ack_ff, nxt_sr_ack;
  logic ref_ack_ff;
  logic [CSR_DW-1:0] ctrl_ff, timing_ff, addrw_ff, rdata_ff;
  logic rvalid_ff;

  wire sr_want = EN_SR && bus.sr_req;
  wire ref_want = EN_REF && bus.ref_req && (run_ff < 4'(MAX_REF_RUN));
  wire ref_fire = (state_ff == ST_REF) && cmd_ready;
  wire sr_fire = (state_ff == ST_ENTER) && cmd_ready && (wait_ff == '0);
  wire exit_fire = (state_ff == ST_EXIT) && cmd_ready && (wait_ff == '0);

  // refresh and self-refresh own the command path; the queue waits
  assign q_hold = (state_ff != ST_IDLE) || ref_want || sr_want
                  || (EN_CSR && ctrl_ff[CTRL_BLOCK_Q_BIT]);
  assign cmd_out = ref_fire ? CMD_REF :
                   sr_fire ? CMD_SR_ENTER :
                   exit_fire ? CMD_SR_EXIT : CMD_NOP;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_wait = (wait_ff != '0) ? wait_ff - 1'b1 : wait_ff;
    nxt_run = run_ff;
    nxt_sr_ack = sr_ack_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (!bus.ref_req)
          nxt_run = '0;
        if (ref_want)
          nxt_state = ST_REF;
        else if (sr_want)
        begin
          nxt_state = ST_ENTER;
          nxt_wait = CNT_W'(SR_ENTRY_CYC);
        end
      end
      ST_REF:
        if (ref_fire)
        begin
          nxt_run = run_ff + 1'b1;
          nxt_state = ST_IDLE;
        end
      ST_ENTER:
        if (sr_fire)
        begin
          nxt_state = ST_IN_SR;
          nxt_sr_ack = 1'b1;
        end
      ST_IN_SR:
        if (!bus.sr_req)
        begin
          nxt_state = ST_EXIT;
          nxt_wait = CNT_W'(SR_EXIT_CYC);
        end
      ST_EXIT:
        if (exit_fire)
        begin
          nxt_state = ST_IDLE;
          nxt_sr_ack = 1'b0;
        end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= ST_IDLE;
      wait_ff <= '0;
      run_ff <= '0;
      sr_ack_ff <= 1'b0;
      ref_ack_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      run_ff <= nxt_run;
      sr_ack_ff <= nxt_sr_ack;
      ref_ack_ff <= ref_fire;
    end
  end

  assign bus.sr_ack = sr_ack_ff;
  assign bus.ref_ack = ref_ack_ff;

  // csr slave: one-cycle write, read data one cycle after the read strobe
  wire csr_wr = EN_CSR && bus.csr_write;
  wire csr_rd = EN_CSR && bus.csr_read;
  wire [CSR_DW-1:0] status_word = {{(CSR_DW-STAT_RUN_LSB-STAT_RUN_W){1'b0}}, run_ff,
                                   {(STAT_RUN_LSB-1){1'b0}}, sr_ack_ff};
  wire [CSR_DW-1:0] rd_mux = (bus.csr_addr == CSR_CTRL) ? ctrl_ff :
                             (bus.csr_addr == CSR_TIMING) ? timing_ff :
                             (bus.csr_addr == CSR_ADDRW) ? addrw_ff :
                             (bus.csr_addr == CSR_STATUS) ? status_word : '0;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_ff <= CTRL_RST;
      timing_ff <= TIMING_RST;
      addrw_ff <= ADDRW_RST;
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      if (csr_wr && bus.csr_addr == CSR_CTRL)
        ctrl_ff <= bus.csr_wdata;
      if (csr_wr && bus.csr_addr == CSR_TIMING)
        timing_ff <= bus.csr_wdata;
      if (csr_wr && bus.csr_addr == CSR_ADDRW)
        addrw_ff <= bus.csr_wdata;
      rdata_ff <= csr_rd ? rd_mux : '0;
      rvalid_ff <= csr_rd;
    end
  end

  assign bus.csr_rdata = rdata_ff;
  assign bus.csr_rvalid = rvalid_ff;
  assign bus.csr_waitreq = 1'b0;
  assign timing_cfg = timing_ff;
  assign addrw_cfg = addrw_ff;
endmodule : ssrc_ctrl
`default_nettype wire

/* File: logic/ssrc_pkg.sv */
// package: shared constants and types of the sdram side-band refresh control
package ssrc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // self-refresh entry and exit settle times in ns
  localparam int unsigned SR_ENTRY_NS = 80;
  localparam int unsigned SR_EXIT_NS = 200;
  localparam int unsigned SR_ENTRY_CYC = (SR_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SR_EXIT_CYC = (SR_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_REF_RUN = 9;
  localparam int unsigned CSR_DW = 32;
  localparam int unsigned CSR_AW = 8;
  localparam int unsigned CNT_W = 8;
  // csr byte addresses, one 32-bit word apart
  localparam logic [CSR_AW-1:0] CSR_CTRL = 8'h00;
  localparam logic [CSR_AW-1:0] CSR_TIMING = 8'h04;
  localparam logic [CSR_AW-1:0] CSR_ADDRW = 8'h08;
  localparam logic [CSR_AW-1:0] CSR_STATUS = 8'h0C;
  localparam logic [CSR_DW-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [CSR_DW-1:0] TIMING_RST = 32'h0000_0000;
  localparam logic [CSR_DW-1:0] ADDRW_RST = 32'h0000_0000;
  localparam int unsigned CTRL_BLOCK_Q_BIT = 0;
  localparam int unsigned STAT_SR_BIT = 0;
  localparam int unsigned STAT_RUN_LSB = 4;
  localparam int unsigned STAT_RUN_W = 4;
  typedef enum logic [1:0] {CMD_NOP, CMD_REF, CMD_SR_ENTER, CMD_SR_EXIT} ssrc_cmd_e;
endpackage : ssrc_pkg

/* File: logic/ssrc_if.sv */
// interface: side-band handshakes and csr port between user logic and controller
`timescale 1ns/1ps
`default_nettype none
interface ssrc_if;
  logic sr_req;
  logic sr_ack;
  logic ref_req;
  logic ref_ack;
  logic csr_read;
  logic csr_write;
  logic [ssrc_pkg::CSR_AW-1:0] csr_addr;
  logic [ssrc_pkg::CSR_DW-1:0] csr_wdata;
  logic [ssrc_pkg::CSR_DW-1:0] csr_rdata;
  logic csr_rvalid;
  logic csr_waitreq;
  modport ctrl (input sr_req, ref_req, csr_read, csr_write, csr_addr, csr_wdata,
                output sr_ack, ref_ack, csr_rdata, csr_rvalid, csr_waitreq);
  modport user (output sr_req, ref_req, csr_read, csr_write, csr_addr, csr_wdata,
                input sr_ack, ref_ack, csr_rdata, csr_rvalid, csr_waitreq);
endinterface : ssrc_if
`default_nettype wire

/* File: logic/ssrc_user.sv */
// user end: drives the side-band handshakes and csr accesses
`timescale 1ns/1ps
`default_nettype none
module ssrc_user (
  input wire logic ref_clk,                  // main controller clock
  input wire logic resetn,                   // async reset, active low
  ssrc_if.user bus,                          // controller side-band and csr
  input wire logic sr_go,                    // level: want self-refresh
  input wire logic [3:0] ref_count,          // refreshes wanted in a burst
  input wire logic ref_start,                // pulse: start refresh burst
  input wire logic csr_rd_go,                // pulse: csr read
  input wire logic csr_wr_go,                // pulse: csr write
  input wire logic [ssrc_pkg::CSR_AW-1:0] csr_addr_in, // csr address
  input wire logic [ssrc_pkg::CSR_DW-1:0] csr_wdata_in, // csr write data
  output logic sr_active,                    // memory in self-refresh
  output logic ref_busy,                     // burst in progress
  output logic [ssrc_pkg::CSR_DW-1:0] csr_rdata_out, // last csr read data
  output logic csr_rdone                     // pulse: read data ready
);
  import ssrc_pkg::*;

  logic sr_req_ff;
  logic [3:0] left_ff;
  logic [CSR_DW-1:0] rdata_ff;
  logic rdone_ff;

  // requests over nine are cut to nine
  wire [3:0] want = (ref_count > 4'(MAX_REF_RUN)) ? 4'(MAX_REF_RUN) : ref_count;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sr_req_ff <= 1'b0;
      left_ff <= '0;
      rdata_ff <= '0;
      rdone_ff <= 1'b0;
    end
    else
    begin
      sr_req_ff <= sr_go;
      if (left_ff == '0 && ref_start)
        left_ff <= want;
      else if (bus.ref_ack && left_ff != '0)
        left_ff <= left_ff - 1'b1;
      if (bus.csr_rvalid)
        rdata_ff <= bus.csr_rdata;
      rdone_ff <= bus.csr_rvalid;
    end
  end

  // request stays high until the last ack; drops in the ack cycle
  assign bus.ref_req = (left_ff > 4'h1) || (left_ff == 4'h1 && !bus.ref_ack);
  assign bus.sr_req = sr_req_ff;
  assign bus.csr_read = csr_rd_go;
  assign bus.csr_write = csr_wr_go && !csr_rd_go;
  assign bus.csr_addr = csr_addr_in;
  assign bus.csr_wdata = csr_wdata_in;
  assign sr_active = bus.sr_ack;
  assign ref_busy = left_ff != '0;
  assign csr_rdata_out = rdata_ff;
  assign csr_rdone = rdone_ff;
endmodule : ssrc_user
`default_nettype wire

/* File: dv/ssrc_assertions.sv */
// checker: timing relations on the side-band handshakes and csr port
`timescale 1ns/1ps
`default_nettype none
module ssrc_assertions (
  input wire logic ref_clk, // main clock
  input wire logic resetn, // async reset, active low
  input wire logic sr_req, // self-refresh request
  input wire logic sr_ack, // self-refresh acknowledge
  input wire logic ref_req, // refresh request
  input wire logic ref_ack, // refresh acknowledge
  input wire logic csr_read, // csr read strobe
  input wire logic csr_rvalid, // csr read data valid
  input wire logic cmd_ready // memory command path can take a command
);
  logic [3:0] run_ff;
  logic [3:0] nxt_run;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // cleared on any low request, so never above the design's own run count
  assign nxt_run = !ref_req ? 4'h0 : run_ff + {3'h0, ref_ack};
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn) run_ff <= 4'h0;
    else run_ff <= nxt_run;
  end
  ack_one_cycle_a: assert property (ref_ack |=> !ref_ack) else $error("ack too long");
  // a held request under the cap is served again two cycles on, unless the path stalled
  ack_spacing_a: assert property (ref_ack && ref_req && run_ff < 4'h8
    |=> !ref_ack ##1 (ref_ack || !$past(cmd_ready))) else $error("held refresh not repeated");
  ack_cause_a: assert property (ref_ack |-> $past(ref_req, 2)) else $error("ack unasked");
  run_cap_a: assert property (run_ff <= 4'h9) else $error("refresh run too long");
  sr_entry_wait_a: assert property ($rose(sr_req) && !sr_ack |=> !sr_ack[*8])
    else $error("sr ack before entry");
  sr_ack_hold_a: assert property (sr_ack && sr_req |=> sr_ack) else $error("sr ack dropped");
  sr_exit_min_a: assert property ($fell(sr_req) && sr_ack |=> sr_ack[*8])
    else $error("sr ack fell before exit");
  sr_exit_max_a: assert property ($fell(sr_req) && sr_ack |-> ##[27:60] !sr_ack)
    else $error("sr ack stuck");
  rd_answer_a: assert property (csr_read |=> csr_rvalid) else $error("no read answer");
  rvalid_cause_a: assert property (csr_rvalid |-> $past(csr_read)) else $error("stray rvalid");
endmodule : ssrc_assertions
`default_nettype wire

/* File: dv/sdram_sideband_refresh_control_bench.sv */
// bench: both ends joined, user end driven through its request inputs
`timescale 1ns/1ps
`default_nettype none
module sdram_sideband_refresh_control_bench;
  import ssrc_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic q_pending = 1'b0, cmd_ready = 1'b1, sr_go = 1'b0, ref_start = 1'b0;
  logic rd_go = 1'b0, wr_go = 1'b0, sr_active, ref_busy, rdone, q_hold;
  logic [3:0] ref_count = 4'h0;
  logic [CSR_AW-1:0] addr = 8'h00;
  logic [CSR_DW-1:0] wdata = 32'h0, rdata, timing_cfg, addrw_cfg;
  ssrc_cmd_e cmd_out;
  int error_cnt = 0, checks_done = 0, n_ref = 0, n_ack = 0, n_enter = 0, n_exit = 0, i;
  always #4 ref_clk = ~ref_clk;
  ssrc_if bus_if ();
  ssrc_ctrl u_ssrc_ctrl (.ref_clk(ref_clk), .resetn(resetn), .bus(bus_if.ctrl),
    .q_pending(q_pending), .cmd_ready(cmd_ready), .cmd_out(cmd_out), .q_hold(q_hold),
    .timing_cfg(timing_cfg), .addrw_cfg(addrw_cfg));
  ssrc_user u_ssrc_user (.ref_clk(ref_clk), .resetn(resetn), .bus(bus_if.user), .sr_go(sr_go),
    .ref_count(ref_count), .ref_start(ref_start), .csr_rd_go(rd_go), .csr_wr_go(wr_go),
    .csr_addr_in(addr), .csr_wdata_in(wdata), .sr_active(sr_active), .ref_busy(ref_busy),
    .csr_rdata_out(rdata), .csr_rdone(rdone));
  ssrc_assertions u_ssrc_assertions (.ref_clk(ref_clk), .resetn(resetn),
    .sr_req(bus_if.sr_req), .sr_ack(bus_if.sr_ack), .ref_req(bus_if.ref_req),
    .ref_ack(bus_if.ref_ack), .csr_read(bus_if.csr_read), .csr_rvalid(bus_if.csr_rvalid),
    .cmd_ready(cmd_ready));
  // sampled mid-cycle so the combinational command has settled
  always @(negedge ref_clk)
  begin
    if (cmd_ready && cmd_out === CMD_REF) n_ref++;
    if (cmd_ready && cmd_out === CMD_SR_ENTER) n_enter++;
    if (cmd_ready && cmd_out === CMD_SR_EXIT) n_exit++;
    if (bus_if.ref_ack === 1'b1) n_ack++;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic csr_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr_go = 1'b1;
    @(negedge ref_clk);
    wr_go = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : csr_wr
  task automatic csr_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    int k;
    @(negedge ref_clk);
    addr = a;
    rd_go = 1'b1;
    @(negedge ref_clk);
    rd_go = 1'b0;
    for (k = 0; k < 8 && rdone !== 1'b1; k++) @(negedge ref_clk);
    chk("rdone", 1, rdone);
    chk("csr read", exp, rdata & msk);
  endtask : csr_rd
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    csr_wr(CSR_TIMING, 32'hA5A5_0F0F);
    chk("timing_cfg", 32'hA5A5_0F0F, timing_cfg);
    csr_wr(CSR_ADDRW, 32'h0000_1C0A);
    chk("addrw_cfg", 32'h0000_1C0A, addrw_cfg);
    csr_rd(CSR_TIMING, 32'hA5A5_0F0F, 32'hFFFF_FFFF);
    csr_rd(CSR_ADDRW, 32'h0000_1C0A, 32'hFFFF_FFFF);
    csr_rd(8'h40, 32'h0, 32'hFFFF_FFFF);
    csr_wr(CSR_CTRL, 32'h1);
    chk("q_hold", 1, q_hold);
    csr_wr(CSR_CTRL, 32'h0);
    $display("csr test done");
    q_pending = 1'b1;
    ref_count = 4'h9;
    ref_start = 1'b1;
    @(negedge ref_clk);
    ref_start = 1'b0;
    chk("q_hold", 1, q_hold);
    for (i = 0; i < 100 && ref_busy !== 1'b0; i++) @(negedge ref_clk);
    chk("refresh cmds", 9, n_ref);
    chk("refresh acks", 9, n_ack);
    // a burst asked for above the cap still yields nine refreshes
    ref_count = 4'hF;
    ref_start = 1'b1;
    @(negedge ref_clk);
    ref_start = 1'b0;
    for (i = 0; i < 100 && ref_busy !== 1'b0; i++) @(negedge ref_clk);
    chk("capped cmds", 18, n_ref);
    chk("capped acks", 18, n_ack);
    $display("refresh test done");
    sr_go = 1'b1;
    for (i = 0; i < 60 && sr_active !== 1'b1; i++) @(negedge ref_clk);
    chk("sr enter", 1, n_enter);
    csr_rd(CSR_STATUS, 32'h1, 32'h1);
    sr_go = 1'b0;
    for (i = 0; i < 80 && sr_active !== 1'b0; i++) @(negedge ref_clk);
    chk("exit wait", 1, i >= 25);
    chk("sr_active", 0, sr_active);
    chk("sr exit", 1, n_exit);
    $display("self-refresh test done");
    report_and_stop();
  end
  initial
  begin
    #(3000 * 8);
    error_cnt++;
    report_and_stop();
  end
endmodule : sdram_sideband_refresh_control_bench
`default_nettype wire
